// File: src/raec_pkg.sv
// constants shared by the alarm-enable and calibration block
package raec_pkg;

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_ALM_TIME = 8'h0C;
   localparam logic [7:0] ADDR_ALM_CAL = 8'h10;
   localparam logic [7:0] ADDR_ALM_EN = 8'h14;
   localparam logic [7:0] ADDR_CAL_CTRL = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;

   // ************************************************************
   // writable bits and reset values
   // ************************************************************
   localparam logic [31:0] ALM_TIME_WMASK = 32'h073F7F7F;
   localparam logic [31:0] ALM_CAL_WMASK = 32'hFFFF1F3F;
   localparam logic [31:0] ALM_EN_WMASK = 32'h000000FF;
   localparam logic [31:0] CAL_CTRL_WMASK = 32'h00000003;
   localparam logic [31:0] IRQ_WMASK = 32'h00000003;
   localparam logic [31:0] ALM_TIME_RST = 32'h00000000;
   localparam logic [31:0] ALM_CAL_RST = 32'h00000000;
   localparam logic [7:0] ALM_EN_RST = 8'h00;
   localparam logic [1:0] CAL_CTRL_RST = 2'h0;
   localparam logic [1:0] IRQ_RST = 2'h0;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int ALM_EN_W = 8;
   localparam int SEC_ON_BIT = 0;
   localparam int MIN_ON_BIT = 1;
   localparam int HOUR_ON_BIT = 2;
   localparam int WDAY_ON_BIT = 3;
   localparam int MDAY_ON_BIT = 4;
   localparam int MONTH_ON_BIT = 5;
   localparam int YEAR_ON_BIT = 6;
   localparam int CENT_ON_BIT = 7;
   localparam int CAL_ON_BIT = 0;
   localparam int CAL_SEL_BIT = 1;
   localparam int IRQ_ALARM_BIT = 0;
   localparam int IRQ_CAL_BIT = 1;
   // lsb and width of each field inside {calendar, time}, by enable bit
   localparam int FLD_LSB [8] = '{0, 8, 16, 24, 32, 40, 48, 56};
   localparam int FLD_W [8] = '{7, 7, 6, 3, 6, 5, 8, 8};

   // ************************************************************
   // calibration period, in seconds
   // ************************************************************
   localparam int CAL_CNT_W = 6;
   localparam logic [5:0] CAL_LONG_SEC = 6'h3C;
   localparam logic [5:0] CAL_SHORT_SEC = 6'h01;

   // ************************************************************
   // bus answers and states
   // ************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP = 2'b10
   } raec_wr_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } raec_rd_t;

endpackage

// File: src/raec_cal_if.sv
// calibration control and apply strobe between register file and timer
`timescale 1ns/100ps
`default_nettype none
interface raec_cal_if;
   logic calOn;
   logic calSel;
   logic secTick;
   logic calApply;
   modport ctrl (output calOn, output calSel, output secTick, input calApply);
   modport timer (input calOn, input calSel, input secTick, output calApply);
endinterface
`default_nettype wire

// File: src/raec_field_cmp.sv
// one alarm field comparison, gated by its enable
`timescale 1ns/100ps
`default_nettype none
module raec_field_cmp #(
   parameter int W = 4
) (
   // field values
   input wire logic [W-1:0] cur,
   input wire logic [W-1:0] alm,
   // field enable
   input wire logic en,
   // result
   output logic hit
);
   // a disabled field never blocks the match
   assign hit = !en || (cur == alm);
endmodule
`default_nettype wire

// File: src/raec_cal_timer.sv
// calibration period timer: one apply strobe per selected period
`timescale 1ns/100ps
`default_nettype none
module raec_cal_timer
   import raec_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // control and strobe
   raec_cal_if.timer cal
);
   logic [CAL_CNT_W-1:0] secCnt_r;
   logic [CAL_CNT_W-1:0] secCnt_nxt;
   logic apply_r;
   logic apply_nxt;
   logic [CAL_CNT_W-1:0] period;

   assign period = cal.calSel ? CAL_SHORT_SEC : CAL_LONG_SEC; // R11

   always_comb begin
      secCnt_nxt = secCnt_r;
      apply_nxt = 1'b0;
      if (!cal.calOn) begin
         secCnt_nxt = '0; // R10
      end else if (cal.secTick) begin
         if (secCnt_r >= period - 6'h01) begin
            secCnt_nxt = '0;
            apply_nxt = 1'b1; // R15
         end else begin
            secCnt_nxt = secCnt_r + 6'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         secCnt_r <= '0;
         apply_r <= 1'b0;
      end else begin
         secCnt_r <= secCnt_nxt;
         apply_r <= apply_nxt;
      end
   end

   assign cal.calApply = apply_r;

   // ************************************************************
   // checks
   // ************************************************************
   // independent count of seconds since the last restart
   logic [6:0] ticks_r;
   logic selPrev_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ticks_r <= 7'h00;
         selPrev_r <= 1'b0;
      end else begin
         selPrev_r <= cal.calSel;
         if (!cal.calOn || apply_r || cal.calSel != selPrev_r) begin
            ticks_r <= 7'h00;
         end else if (cal.secTick) begin
            ticks_r <= ticks_r + 7'h01;
         end
      end
   end

   sequence lastTick_s;
      cal.calOn && cal.secTick && cal.calSel == selPrev_r && !apply_r
         && ticks_r == (cal.calSel ? 7'h00 : 7'h3B);
   endsequence

   period_end_a: assert property (@(posedge sys_clk) disable iff (rst) lastTick_s |=> cal.calApply) // R11
      else $error("calibration strobe missing at period end");
   cal_off_a: assert property (@(posedge sys_clk) disable iff (rst) !cal.calOn |=> !cal.calApply) // R10
      else $error("calibration strobe while calibration is off");
   apply_once_a: assert property (@(posedge sys_clk) disable iff (rst) cal.calApply |-> $past(cal.secTick)) // R15
      else $error("calibration strobe without a seconds tick");
endmodule
`default_nettype wire

// File: src/raec_top.sv
// alarm field enables, alarm values and calibration control behind AXI4-Lite
// Function
// R1: century alarm enable, bit 7, resets 0; set adds century to comparison.
// R2: year alarm enable, bit 6, resets 0; set adds year to comparison.
// R3: month alarm enable, bit 5, resets 0; set adds month to comparison.
// R4: day-of-month alarm enable, bit 4, resets 0; set adds it to comparison.
// R5: weekday alarm enable, bit 3, resets 0; set adds weekday to comparison.
// R6: hour alarm enable, bit 2, resets 0; set adds hour to comparison.
// R7: minute alarm enable, bit 1, resets 0; set adds minute to comparison.
// R8: second alarm enable, bit 0, resets 0; set adds seconds to comparison.
// R9: upper enable bits and calibration bits 31:2 read zero, ignore writes.
// R10: calibration enable, bit 0, resets 0; calibration runs only while set.
// R11: period select bit 1: zero gives 60 seconds, one gives 1 second.
// R12: alarm values per field are BCD tens and units, written by software.
// R13: alarm matches when running time and calendar equal the alarm values.
// R14: match only when all enabled fields equal; none enabled, never match.
// R15: one calibration correction at the end of each selected period.
`timescale 1ns/100ps
`default_nettype none
module raec_top
   import raec_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // axi4-lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // running time and calendar from the counters
   input wire logic [31:0] curTime,
   input wire logic [31:0] curCal,
   input wire logic secTick,
   // to the counters and trigger logic
   output logic [ALM_EN_W-1:0] alarmFieldOn,
   output logic [31:0] alarmTimeValues,
   output logic [31:0] alarmCalendarValues,
   output logic alarmMatch,
   output logic calFunctionOn,
   output logic calPeriodSelect,
   output logic calApply,
   output logic irq
);

   // ************************************************************
   // declarations
   // ************************************************************
   raec_wr_t wrState_r, wrState_nxt;
   raec_rd_t rdState_r, rdState_nxt;
   logic awHeld_r, awHeld_nxt;
   logic wHeld_r, wHeld_nxt;
   logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
   logic [31:0] wData_r, wData_nxt;
   logic [3:0] wStrb_r, wStrb_nxt;
   logic [1:0] bResp_r, bResp_nxt;
   logic [31:0] rData_r, rData_nxt;
   logic [1:0] rResp_r, rResp_nxt;
   logic wrEn;
   logic [31:0] almTime_r, almTime_nxt;
   logic [31:0] almCal_r, almCal_nxt;
   logic [ALM_EN_W-1:0] almEn_r, almEn_nxt;
   logic [1:0] calCtrl_r, calCtrl_nxt;
   logic [1:0] irqStat_r, irqStat_nxt;
   logic [1:0] irqMask_r, irqMask_nxt;
   logic match_r, match_nxt;
   logic [1:0] events;
   logic [63:0] curAll;
   logic [63:0] almAll;
   logic [ALM_EN_W-1:0] fieldHit;
   raec_cal_if calBus ();

   // ************************************************************
   // helpers
   // ************************************************************
   // byte-lane merge; bits outside the mask stay as they were
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] lanes;
      lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
      return (old & ~lanes) | (data & lanes);
   endfunction
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a == ADDR_ALM_TIME || a == ADDR_ALM_CAL || a == ADDR_ALM_EN
         || a == ADDR_CAL_CTRL || a == ADDR_IRQ_STAT || a == ADDR_IRQ_MASK;
   endfunction

   // ************************************************************
   // axi write channel
   // ************************************************************
   assign s_axi_awready = (wrState_r == WR_COLLECT) && !awHeld_r;
   assign s_axi_wready = (wrState_r == WR_COLLECT) && !wHeld_r;
   assign s_axi_bvalid = (wrState_r == WR_RESP);
   assign s_axi_bresp = bResp_r;
   // address and data may come in either order; commit once both are held
   assign wrEn = (wrState_r == WR_COLLECT) && awHeld_r && wHeld_r;
   always_comb begin
      wrState_nxt = wrState_r;
      awHeld_nxt = awHeld_r;
      wHeld_nxt = wHeld_r;
      awAddr_nxt = awAddr_r;
      wData_nxt = wData_r;
      wStrb_nxt = wStrb_r;
      bResp_nxt = bResp_r;
      case (wrState_r)
         WR_COLLECT: begin
            if (s_axi_awvalid && s_axi_awready) begin
               awHeld_nxt = 1'b1;
               awAddr_nxt = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               wHeld_nxt = 1'b1;
               wData_nxt = s_axi_wdata;
               wStrb_nxt = s_axi_wstrb;
            end
            if (wrEn) begin
               bResp_nxt = mapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
               wrState_nxt = WR_RESP;
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               awHeld_nxt = 1'b0;
               wHeld_nxt = 1'b0;
               wrState_nxt = WR_COLLECT;
            end
         end
         default: begin
            wrState_nxt = WR_COLLECT;
            awHeld_nxt = 1'b0;
            wHeld_nxt = 1'b0;
         end
      endcase
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wrState_r <= WR_COLLECT;
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= '0;
         wData_r <= 32'h00000000;
         wStrb_r <= 4'h0;
         bResp_r <= RESP_OKAY;
      end else begin
         wrState_r <= wrState_nxt;
         awHeld_r <= awHeld_nxt;
         wHeld_r <= wHeld_nxt;
         awAddr_r <= awAddr_nxt;
         wData_r <= wData_nxt;
         wStrb_r <= wStrb_nxt;
         bResp_r <= bResp_nxt;
      end
   end

   // ************************************************************
   // axi read channel
   // ************************************************************
   assign s_axi_arready = (rdState_r == RD_IDLE);
   assign s_axi_rvalid = (rdState_r == RD_DATA);
   assign s_axi_rdata = rData_r;
   assign s_axi_rresp = rResp_r;
   always_comb begin
      rdState_nxt = rdState_r;
      rData_nxt = rData_r;
      rResp_nxt = rResp_r;
      case (rdState_r)
         RD_IDLE: begin
            if (s_axi_arvalid) begin
               rResp_nxt = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
               rData_nxt = 32'h00000000;
               case (s_axi_araddr)
                  ADDR_ALM_TIME: rData_nxt = almTime_r;
                  ADDR_ALM_CAL: rData_nxt = almCal_r;
                  ADDR_ALM_EN: rData_nxt = {24'h000000, almEn_r}; // R9
                  ADDR_CAL_CTRL: rData_nxt = {30'h00000000, calCtrl_r}; // R9
                  ADDR_IRQ_STAT: rData_nxt = {30'h00000000, irqStat_r};
                  ADDR_IRQ_MASK: rData_nxt = {30'h00000000, irqMask_r};
                  default: rData_nxt = 32'h00000000;
               endcase
               rdState_nxt = RD_DATA;
            end
         end
         RD_DATA: begin
            if (s_axi_rready) begin
               rdState_nxt = RD_IDLE;
            end
         end
         default: rdState_nxt = RD_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdState_r <= RD_IDLE;
         rData_r <= 32'h00000000;
         rResp_r <= RESP_OKAY;
      end else begin
         rdState_r <= rdState_nxt;
         rData_r <= rData_nxt;
         rResp_r <= rResp_nxt;
      end
   end

   // ************************************************************
   // register file
   // ************************************************************
   // alarm event fires on the rising edge of the match, not while it lasts
   assign events[IRQ_ALARM_BIT] = match_nxt && !match_r;
   assign events[IRQ_CAL_BIT] = calBus.calApply;
   always_comb begin
      logic [31:0] en32;
      logic [31:0] cc32;
      logic [31:0] st32;
      logic [31:0] mk32;
      en32 = merge({24'h000000, almEn_r}, wData_r, wStrb_r, ALM_EN_WMASK);
      cc32 = merge({30'h00000000, calCtrl_r}, wData_r, wStrb_r, CAL_CTRL_WMASK);
      st32 = wData_r & {{24{1'b0}}, {8{wStrb_r[0]}}} & IRQ_WMASK;
      mk32 = merge({30'h00000000, irqMask_r}, wData_r, wStrb_r, IRQ_WMASK);
      almTime_nxt = almTime_r;
      almCal_nxt = almCal_r;
      almEn_nxt = almEn_r;
      calCtrl_nxt = calCtrl_r;
      irqMask_nxt = irqMask_r;
      irqStat_nxt = irqStat_r;
      if (wrEn) begin
         case (awAddr_r)
            ADDR_ALM_TIME: almTime_nxt = merge(almTime_r, wData_r, wStrb_r, ALM_TIME_WMASK); // R12
            ADDR_ALM_CAL: almCal_nxt = merge(almCal_r, wData_r, wStrb_r, ALM_CAL_WMASK); // R12
            ADDR_ALM_EN: almEn_nxt = en32[ALM_EN_W-1:0]; // R9
            ADDR_CAL_CTRL: calCtrl_nxt = cc32[1:0]; // R9
            ADDR_IRQ_STAT: irqStat_nxt = irqStat_r & ~st32[1:0];
            ADDR_IRQ_MASK: irqMask_nxt = mk32[1:0];
            default: irqMask_nxt = irqMask_r;
         endcase
      end
      // a new event wins over a clear in the same cycle
      irqStat_nxt = irqStat_nxt | events;
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         almTime_r <= ALM_TIME_RST;
         almCal_r <= ALM_CAL_RST;
         almEn_r <= ALM_EN_RST; // R1 R2 R3 R4 R5 R6 R7 R8
         calCtrl_r <= CAL_CTRL_RST; // R10 R11
         irqStat_r <= IRQ_RST;
         irqMask_r <= IRQ_RST;
      end else begin
         almTime_r <= almTime_nxt;
         almCal_r <= almCal_nxt;
         almEn_r <= almEn_nxt;
         calCtrl_r <= calCtrl_nxt;
         irqStat_r <= irqStat_nxt;
         irqMask_r <= irqMask_nxt;
      end
   end

   // ************************************************************
   // alarm comparison
   // ************************************************************
   assign curAll = {curCal, curTime};
   assign almAll = {almCal_r, almTime_r};
   for (genvar i = 0; i < ALM_EN_W; i++) begin : gFld
      raec_field_cmp #(
         .W(FLD_W[i])
      ) uCmp (
         .cur(curAll[FLD_LSB[i] +: FLD_W[i]]), // R13
         .alm(almAll[FLD_LSB[i] +: FLD_W[i]]),
         .en(almEn_r[i]), // R1 R2 R3 R4 R5 R6 R7 R8
         .hit(fieldHit[i])
      );
   end
   // with no field enabled the all-hit would be trivially true
   assign match_nxt = (|almEn_r) && (&fieldHit); // R14
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         match_r <= 1'b0;
      end else begin
         match_r <= match_nxt;
      end
   end

   // ************************************************************
   // calibration
   // ************************************************************
   assign calBus.calOn = calCtrl_r[CAL_ON_BIT]; // R10
   assign calBus.calSel = calCtrl_r[CAL_SEL_BIT]; // R11
   assign calBus.secTick = secTick;
   raec_cal_timer uCal (
      .sys_clk(sys_clk),
      .rst(rst),
      .cal(calBus.timer)
   );

   // ************************************************************
   // outputs
   // ************************************************************
   assign alarmFieldOn = almEn_r;
   assign alarmTimeValues = almTime_r;
   assign alarmCalendarValues = almCal_r;
   assign alarmMatch = match_r;
   assign calFunctionOn = calCtrl_r[CAL_ON_BIT];
   assign calPeriodSelect = calCtrl_r[CAL_SEL_BIT];
   assign calApply = calBus.calApply;
   assign irq = |(irqStat_r & irqMask_r);

   // ************************************************************
   // checks
   // ************************************************************
   logic [ADDR_W-1:0] rdAddr_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdAddr_r <= '0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rdAddr_r <= s_axi_araddr;
      end
   end
   sequence enWrite_s;
      wrEn && awAddr_r == ADDR_ALM_EN && wStrb_r[0];
   endsequence
   sequence fieldMiss_s;
      (almEn_r & ~fieldHit) != '0;
   endsequence
   en_write_a: assert property (@(posedge sys_clk) disable iff (rst)
      enWrite_s |=> alarmFieldOn == $past(wData_r[7:0])) // R1
      else $error("alarm enable write not taken");
   none_on_a: assert property (@(posedge sys_clk) disable iff (rst)
      alarmFieldOn == 8'h00 |=> !alarmMatch) // R14
      else $error("match with no field enabled");
   field_miss_a: assert property (@(posedge sys_clk) disable iff (rst)
      fieldMiss_s |=> !alarmMatch) // R13
      else $error("match despite an enabled field differing");
   full_hit_a: assert property (@(posedge sys_clk) disable iff (rst)
      (alarmFieldOn != 8'h00 && curAll == almAll && !wrEn) |=> alarmMatch) // R13
      else $error("no match although all fields equal");
   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      s_axi_rvalid && rdAddr_r == ADDR_ALM_EN |-> s_axi_rdata[31:8] == 24'h000000) // R9
      else $error("reserved enable bits read nonzero");
   cal_reserved_a: assert property (@(posedge sys_clk) disable iff (rst)
      s_axi_rvalid && rdAddr_r == ADDR_CAL_CTRL |-> s_axi_rdata[31:2] == 30'h00000000) // R9
      else $error("reserved calibration bits read nonzero");
   cal_write_a: assert property (@(posedge sys_clk) disable iff (rst)
      wrEn && awAddr_r == ADDR_CAL_CTRL && wStrb_r[0] |=> calFunctionOn == $past(wData_r[0])
         && calPeriodSelect == $past(wData_r[1])) // R10
      else $error("calibration control write not taken");
   resp_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   irq_level_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(match_r) |-> irqStat_r[IRQ_ALARM_BIT])
      else $error("alarm event not recorded");
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the alarm-enable and calibration block
`timescale 1ns/100ps
`default_nettype none
module tb import raec_pkg::*; ;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
      logic [31:0] expd;
      logic [1:0] resp;
   } raec_row_t;
   // ************************************************************
   // ordinary register cases
   // ************************************************************
   localparam raec_row_t ROWS [8] = '{
      '{ADDR_ALM_EN, 32'hFFFFFFFF, 4'hF, 32'h000000FF, RESP_OKAY},
      '{ADDR_ALM_EN, 32'h000000A5, 4'hF, 32'h000000A5, RESP_OKAY},
      '{ADDR_ALM_EN, 32'h0000005A, 4'h0, 32'h000000A5, RESP_OKAY},
      '{ADDR_CAL_CTRL, 32'hFFFFFFFF, 4'hF, 32'h00000003, RESP_OKAY},
      '{ADDR_CAL_CTRL, 32'h00000001, 4'hF, 32'h00000001, RESP_OKAY},
      '{ADDR_ALM_TIME, 32'hFFFFFFFF, 4'hF, 32'h073F7F7F, RESP_OKAY},
      '{ADDR_ALM_CAL, 32'hFFFFFFFF, 4'hF, 32'hFFFF1F3F, RESP_OKAY},
      '{8'h40, 32'hFFFFFFFF, 4'hF, 32'h00000000, RESP_SLVERR}};
   logic sys_clk = 0, rst = 1;
   logic [7:0] awaddr = 0, araddr = 0, alarmFieldOn;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, secTick = 0;
   logic awready, wready, bvalid, arready, rvalid, alarmMatch, calOn, calSel, calApply, irq;
   logic [31:0] wdata = 0, rdata, curTime = 0, curCal = 0, aTime, aCal, rd;
   logic [3:0] wstrb = 0;
   logic [1:0] bresp, rresp, resp;
   logic [63:0] alm = {32'h20211225, 32'h03123456};
   int nErrors = 0, cmpCount = 0, applyCnt = 0, base, i;

   raec_top raec_top_i (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .curTime(curTime),
      .curCal(curCal), .secTick(secTick), .alarmFieldOn(alarmFieldOn), .alarmTimeValues(aTime),
      .alarmCalendarValues(aCal), .alarmMatch(alarmMatch), .calFunctionOn(calOn),
      .calPeriodSelect(calSel), .calApply(calApply), .irq(irq));

   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (calApply === 1'b1) applyCnt <= applyCnt + 1;

   // ************************************************************
   // shared tasks
   // ************************************************************
   task check(input string n, input logic [31:0] e, input logic [31:0] s);
      cmpCount++;
      if (s !== e) begin
         nErrors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task complete_run;
      $display("counts: %0d mismatches in %0d comparisons", nErrors, cmpCount);
      if (nErrors == 0 && cmpCount > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ends one edge late so the next call never re-drives a signal in the same step
   task axiWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw, w;
      aw = 0;
      w = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(aw && w)) begin
         @(posedge sys_clk);
         if (!aw && awready === 1'b1) begin aw = 1; awvalid <= 0; end
         if (!w && wready === 1'b1) begin w = 1; wvalid <= 0; end
      end
      while (bvalid !== 1'b1) @(posedge sys_clk);
      resp = bresp;
      bready <= 0;
      @(posedge sys_clk);
   endtask
   task axiRd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 0;
      @(posedge sys_clk);
   endtask
   task tick;
      secTick <= 1;
      @(posedge sys_clk);
      secTick <= 0;
      repeat (3) @(posedge sys_clk);
   endtask
   task setCur(input logic [63:0] v);
      {curCal, curTime} <= v;
      repeat (3) @(posedge sys_clk);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      check("reset outputs", 0, {alarmFieldOn, calOn, calSel, alarmMatch, calApply, irq});
      axiRd(ADDR_ALM_EN);
      check("enables reset", 0, rd);
      axiRd(ADDR_CAL_CTRL);
      check("calibration reset", 0, rd);
      $display("test reset done");
      foreach (ROWS[k]) begin
         axiWr(ROWS[k].addr, ROWS[k].data, ROWS[k].strb);
         check("write resp", ROWS[k].resp, resp);
         axiRd(ROWS[k].addr);
         check("readback", ROWS[k].expd, rd);
         check("read resp", ROWS[k].resp, resp);
         if (ROWS[k].addr == ADDR_ALM_EN) check("field enables", ROWS[k].expd, {24'h0, alarmFieldOn});
         if (ROWS[k].addr == ADDR_CAL_CTRL) check("cal outputs", ROWS[k].expd, {30'h0, calSel, calOn});
      end
      $display("test registers done");
      axiWr(ADDR_ALM_TIME, alm[31:0], 4'hF);
      axiWr(ADDR_ALM_CAL, alm[63:32], 4'hF);
      check("alarm time out", alm[31:0], aTime);
      check("alarm cal out", alm[63:32], aCal);
      axiWr(ADDR_ALM_EN, 0, 4'hF);
      setCur(alm);
      check("match none on", 0, {31'h0, alarmMatch});
      // each enable alone: its field decides, the neighbour field is ignored
      for (i = 0; i < 8; i++) begin
         axiWr(ADDR_ALM_EN, 32'h1 << i, 4'hF);
         setCur(alm);
         check("match equal", 1, {31'h0, alarmMatch});
         setCur(alm ^ (64'h1 << FLD_LSB[i]));
         check("match field off", 0, {31'h0, alarmMatch});
         setCur(alm ^ (64'h1 << FLD_LSB[(i + 1) % 8]));
         check("match other", 1, {31'h0, alarmMatch});
      end
      $display("test alarm done");
      axiRd(ADDR_IRQ_STAT);
      check("alarm event", 32'h1, rd & 32'h1);
      check("irq masked", 0, {31'h0, irq});
      axiWr(ADDR_IRQ_MASK, 32'h1, 4'hF);
      check("irq unmasked", 1, {31'h0, irq});
      axiWr(ADDR_ALM_EN, 0, 4'hF);
      axiWr(ADDR_IRQ_STAT, 32'h1, 4'hF);
      axiRd(ADDR_IRQ_STAT);
      check("event cleared", 0, rd & 32'h1);
      check("irq cleared", 0, {31'h0, irq});
      $display("test interrupt done");
      axiWr(ADDR_CAL_CTRL, 0, 4'hF);
      base = applyCnt;
      repeat (3) tick;
      check("cal off", 0, applyCnt - base);
      axiWr(ADDR_CAL_CTRL, 32'h3, 4'hF);
      base = applyCnt;
      repeat (3) tick;
      check("short period", 3, applyCnt - base);
      axiWr(ADDR_CAL_CTRL, 0, 4'hF);
      axiWr(ADDR_CAL_CTRL, 32'h1, 4'hF);
      base = applyCnt;
      repeat (59) tick;
      check("long period early", 0, applyCnt - base);
      tick;
      check("long period end", 1, applyCnt - base);
      axiRd(ADDR_IRQ_STAT);
      check("cal event", 32'h2, rd & 32'h2);
      $display("test calibration done");
      // reset in mid-run with calibration on and a status bit set
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      check("reset again", 0, {alarmFieldOn, calOn, calSel, alarmMatch, calApply, irq});
      axiRd(ADDR_IRQ_STAT);
      check("status reset", 0, rd);
      $display("test mid reset done");
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      nErrors++;
      complete_run;
   end
endmodule
`default_nettype wire
